// ===== pkg/cell_monitor_regs.svh
// Purpose: register map, field values and timing figures of the cell monitor core
// Assumes: 8-bit register port, 40 MHz core clock
// Notes: times are in their printed units; cycle counts are derived in the modules
`ifndef CELL_MONITOR_REGS_SVH
`define CELL_MONITOR_REGS_SVH
`define CFG0_ADDR    4'h0
`define CFG1_ADDR    4'h1
`define CFG2_ADDR    4'h2
`define CFG3_ADDR    4'h3
`define CFG4_ADDR    4'h4
`define CFG5_ADDR    4'h5
`define STATUS_ADDR  4'h6
`define RSEL_ADDR    4'h7
`define RLO_ADDR     4'h8
`define RHI_ADDR     4'h9
`define UVLO_ADDR    4'hA
`define UVHI_ADDR    4'hB
`define OVLO_ADDR    4'hC
`define OVHI_ADDR    4'hD
`define CDC_STANDBY  3'h0
`define CDC_MON_MIN  3'h2
`define TEN_CELL_SELECT_MASK  12'hC00
`define ADC_OFFSET   12'h200
`define RES_CLEARED  12'hFFF
`define TEST_PAT_A   12'h555
`define TEST_PAT_B   12'hAAA
`define REF_CHAN     5'h0F
`define NO_CHAN      5'h10
`define TEMP_SKIP    4'h8
`define CMD_CELL     4'h1
`define CMD_OW       4'h2
`define CMD_CELL_DC  4'h3
`define CMD_OW_DC    4'h4
`define CMD_CLEAR    4'h5
`define CMD_TEST_A   4'h6
`define CMD_TEST_B   4'h7
`define CMD_DIAG     4'h8
`define CLK_KHZ      40000
`define WD_TIME_MS   1000
`define CLR_TIME_US  1000
`define DIAG_TIME_US 16400
`define MON_TIME_MS  13
`endif

// ===== pkg/cell_monitor_pkg.sv
// Purpose: types shared by the cell monitor core and its helpers
// Assumes: constants come from cell_monitor_regs.svh
// Notes: power-up configuration is standby with all discharge off
package cell_monitor_pkg;
    `include "cell_monitor_regs.svh"

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_REQ   = 3'b001,
        S_WAIT  = 3'b011,
        S_CLEAR = 3'b010,
        S_DIAG  = 3'b110
    } seq_state_type;

    typedef enum logic [2:0] {
        MD_CELL, MD_CELL_DC, MD_OW, MD_OW_DC, MD_TEST_A, MD_TEST_B, MD_MON, MD_DIAG
    } conv_mode_type;

    typedef struct packed {
        logic [2:0]  comparator_duty_cycle;
        logic        ten_cell_select;
        logic        general_pin_one;
        logic        general_pin_two;
        logic [11:0] dischargeCfg;
        logic [11:0] channel_mask_bit;
        logic [7:0]  undervoltage_limit;
        logic [7:0]  overvoltage_limit;
    } cfg_type;

    localparam cfg_type CFG_DEFAULT = '{`CDC_STANDBY, 1'b0, 1'b1, 1'b1, 12'h000, 12'h000, 8'h00, 8'hFF};

    typedef struct packed {
        logic [31:0] cnt;
        logic        alarm;
        logic        expire;
    } wd_state_type;
endpackage : cell_monitor_pkg

// ===== logic/pin_sync.sv
// Purpose: two-stage synchroniser for pins sampled by the core clock
// Assumes: pins change slowly compared to the clock
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // pins in, synchronised levels out
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync
);
    typedef struct packed { logic [W-1:0] s1; logic [W-1:0] s2; } sync_state_type;
    sync_state_type q, d;
    if (W < 1) $error("pin_sync width must be at least one");
    always_comb begin
        d = q;
        d.s1 = pinIn;
        d.s2 = q.s1;
    end
    always_ff @(posedge clk) begin
        if (!rstn) q <= '0;
        else q <= d;
    end
    assign pinSync = q.s2;
endmodule : pin_sync

// ===== logic/watchdog_timer.sv
// Purpose: communication watchdog with sticky alarm
// Assumes: kick is a one-cycle pulse per accepted command
// Notes: expire is a one-cycle pulse; alarm holds until the next kick
`timescale 1ns/10ps
module watchdog_timer
    import cell_monitor_pkg::*;
#(
    parameter int WD_CYC = `WD_TIME_MS * `CLK_KHZ
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // control
    input  wire logic enable,
    input  wire logic kick,
    // results
    output logic      expire,
    output logic      alarm
);
    wd_state_type q, d;
    if (WD_CYC < 2) $error("watchdog period too short");
    always_comb begin
        d = q;
        d.expire = 1'b0;
        if (!enable || kick) d.cnt = 32'h0;
        else if (q.cnt >= 32'(WD_CYC - 1)) begin
            d.cnt = 32'h0;
            d.expire = 1'b1;
        end else d.cnt = q.cnt + 32'h1;
        if (kick) d.alarm = 1'b0;
        else if (d.expire) d.alarm = 1'b1;
    end
    always_ff @(posedge clk) begin
        if (!rstn) q <= '0;
        else q <= d;
    end
    assign expire = q.expire;
    assign alarm  = q.alarm;

    idle_standby_a: assert property (@(posedge clk) disable iff (!rstn) !enable |=> q.cnt == 32'h0 && !expire)
        else $error("watchdog counted in standby");
    alarm_hold_a: assert property (@(posedge clk) disable iff (!rstn) alarm && !kick |=> alarm)
        else $error("alarm released without a valid command");
    alarm_cause_a: assert property (@(posedge clk) disable iff (!rstn) $rose(alarm) |-> expire)
        else $error("alarm raised without expiry");
endmodule : watchdog_timer

// ===== logic/cell_monitor_core.sv
// Purpose: measurement sequencer, limit flags, diagnostics, pins and watchdog of a stack monitor
// Assumes: serial layer delivers PACKET_ERROR_CODE-checked commands; ADC answers each request once
// Notes: register port is 8 bits wide with read data one cycle after the strobe
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module cell_monitor_core
    import cell_monitor_pkg::*;
#(
    parameter int CLR_CYC  = `CLR_TIME_US * (`CLK_KHZ / 1000),
    parameter int DIAG_CYC = `DIAG_TIME_US * (`CLK_KHZ / 1000),
    parameter int MON_CYC  = `MON_TIME_MS * `CLK_KHZ,
    parameter int WD_CYC   = `WD_TIME_MS * `CLK_KHZ
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [7:0]  regRdata,
    // commands from the serial layer
    input  wire logic        cmdValid,
    input  wire logic [3:0]  cmdCode,
    input  wire logic        cmdPecOk,
    // polling status
    output logic             convBusy,
    output logic             limitAlarm,
    // converter
    output logic             adcReq,
    output logic      [3:0]  adcChan,
    output logic             adcOpenWire,
    input  wire logic        adcDone,
    input  wire logic [11:0] adcRaw,
    input  wire logic        adcMuxOk,
    // discharge switches
    output logic      [11:0] dischargeOn,
    // open-drain pins
    input  wire logic [1:0]  gpioIn,
    output logic      [1:0]  gpioOut,
    output logic      [1:0]  gpioOeN,
    input  wire logic        wdAlarmIn,
    output logic             wdAlarmOut,
    output logic             wdAlarmOeN
);
    typedef struct packed {
        cfg_type        cfg;
        seq_state_type  st;
        conv_mode_type  mode;
        logic [4:0]     chan;
        logic [31:0]    cnt;
        logic [31:0]    monCnt;
        logic [15:0][11:0] res;
        logic [11:0]    uvFlag;
        logic [11:0]    ovFlag;
        logic           muxFail;
        logic [11:0]    dis;
        logic [7:0]     rdata;
        logic [3:0]     rsel;
    } core_state_type;

    core_state_type q, d;
    logic [2:0]  pinSync;
    logic        wdExpire;
    logic        wdAlarm;
    logic        cmdOk;
    logic        measure;
    logic [11:0] chanMask;
    logic [11:0] code;
    logic [4:0]  nxt;
    logic        startCmd;
    conv_mode_type startMode;

    if (CLR_CYC < 1 || DIAG_CYC < 2 || MON_CYC < 1) $error("cycle counts too small");

    // lowest unskipped channel at or above from, NO_CHAN when none
    function automatic logic [4:0] seekChan(input logic [4:0] from, input logic [15:0] skip);
        logic [4:0] r;
        r = `NO_CHAN;
        for (int i = 15; i >= 0; i--) begin
            if (5'(i) >= from && !skip[i]) r = 5'(i);
        end
        return r;
    endfunction : seekChan

    // temperature channels only join the self tests; the reference slot never does
    function automatic logic [15:0] skipFor(input conv_mode_type m, input logic [11:0] msk);
        if (m == MD_TEST_A || m == MD_TEST_B) return {`TEMP_SKIP, msk};
        return {4'hF, msk};
    endfunction : skipFor

    function automatic logic isCellMode(input conv_mode_type m);
        return m == MD_CELL || m == MD_CELL_DC || m == MD_MON;
    endfunction : isCellMode

    // measured cell plus the ones directly above and below
    function automatic logic [11:0] neighbours(input logic [4:0] c);
        logic [13:0] t;
        t = 14'h0007 << c[3:0];
        return (c < 5'h0C) ? t[12:1] : 12'h000;
    endfunction : neighbours

    function automatic logic [11:0] toCode(input logic [11:0] raw);
        return raw + `ADC_OFFSET;
    endfunction : toCode

    pin_sync #(.W(3)) u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .pinIn   ({wdAlarmIn, gpioIn}),
        .pinSync (pinSync)
    );

    // register writes stand for PACKET_ERROR_CODE-checked configuration writes
    watchdog_timer #(.WD_CYC(WD_CYC)) u_wd (
        .clk    (clk),
        .rstn   (rstn),
        .enable (q.cfg.comparator_duty_cycle != `CDC_STANDBY),
        .kick   (cmdOk || regWr),
        .expire (wdExpire),
        .alarm  (wdAlarm)
    );

    always_comb begin
        d = q;
        cmdOk = cmdValid && cmdPecOk;
        measure = q.cfg.comparator_duty_cycle != `CDC_STANDBY;
        chanMask = q.cfg.channel_mask_bit | (q.cfg.ten_cell_select ? `TEN_CELL_SELECT_MASK : 12'h000);
        case (q.mode)
            MD_TEST_A: code = `TEST_PAT_A;
            MD_TEST_B: code = `TEST_PAT_B;
            default:   code = toCode(adcRaw);
        endcase
        nxt = seekChan(q.chan + 5'h01, skipFor(q.mode, chanMask));
        startCmd = 1'b0;
        startMode = MD_CELL;

        // register writes
        if (regWr) begin
            case (regAddr)
                `CFG0_ADDR: begin
                    d.cfg.comparator_duty_cycle = regWdata[2:0];
                    d.cfg.ten_cell_select = regWdata[3];
                    d.cfg.general_pin_one = regWdata[5];
                    d.cfg.general_pin_two = regWdata[6];
                end
                `CFG1_ADDR: d.cfg.dischargeCfg[7:0] = regWdata;
                `CFG2_ADDR: begin
                    d.cfg.dischargeCfg[11:8] = regWdata[3:0];
                    d.cfg.channel_mask_bit[3:0] = regWdata[7:4];
                end
                `CFG3_ADDR: d.cfg.channel_mask_bit[11:4] = regWdata;
                `CFG4_ADDR: d.cfg.undervoltage_limit = regWdata;
                `CFG5_ADDR: d.cfg.overvoltage_limit = regWdata;
                `RSEL_ADDR: d.rsel = regWdata[3:0];
                default: ;
            endcase
        end

        // read data stands only in the cycle after the strobe
        d.rdata = 8'h00;
        if (regRd) begin
            case (regAddr)
                `CFG0_ADDR: d.rdata = {pinSync[2], pinSync[1], pinSync[0], 1'b0,
                                       q.cfg.ten_cell_select, q.cfg.comparator_duty_cycle};
                `CFG1_ADDR: d.rdata = q.cfg.dischargeCfg[7:0];
                `CFG2_ADDR: d.rdata = {q.cfg.channel_mask_bit[3:0], q.cfg.dischargeCfg[11:8]};
                `CFG3_ADDR: d.rdata = q.cfg.channel_mask_bit[11:4];
                `CFG4_ADDR: d.rdata = q.cfg.undervoltage_limit;
                `CFG5_ADDR: d.rdata = q.cfg.overvoltage_limit;
                `STATUS_ADDR: d.rdata = {5'h00, q.muxFail, limitAlarm, convBusy};
                `RSEL_ADDR: d.rdata = {4'h0, q.rsel};
                `RLO_ADDR:  d.rdata = q.res[q.rsel][7:0];
                `RHI_ADDR:  d.rdata = {4'h0, q.res[q.rsel][11:8]};
                `UVLO_ADDR: d.rdata = q.uvFlag[7:0];
                `UVHI_ADDR: d.rdata = {4'h0, q.uvFlag[11:8]};
                `OVLO_ADDR: d.rdata = q.ovFlag[7:0];
                `OVHI_ADDR: d.rdata = {4'h0, q.ovFlag[11:8]};
                default:    d.rdata = 8'h00;
            endcase
        end

        // sequencer
        if (q.st != S_IDLE) d.cnt = q.cnt + 32'h1;
        if (q.monCnt != 32'h0) d.monCnt = q.monCnt - 32'h1;
        case (q.st)
            S_IDLE: begin
                if (q.cfg.comparator_duty_cycle >= `CDC_MON_MIN && q.monCnt == 32'h0) begin
                    startCmd = 1'b1;
                    startMode = MD_MON;
                    d.monCnt = 32'(MON_CYC) << (q.cfg.comparator_duty_cycle - `CDC_MON_MIN);
                end
            end
            S_REQ: d.st = S_WAIT;
            S_WAIT: begin
                if (adcDone) begin
                    if (q.mode == MD_DIAG) begin
                        d.res[`REF_CHAN] = code;
                        d.muxFail = !adcMuxOk;
                        d.st = S_DIAG;
                    end else begin
                        if (q.mode != MD_MON) d.res[q.chan[3:0]] = code;
                        // comparisons run on the offset code; limits are its upper byte
                        if (isCellMode(q.mode)) begin
                            d.uvFlag[q.chan[3:0]] = code < {q.cfg.undervoltage_limit, 4'h0};
                            d.ovFlag[q.chan[3:0]] = code > {q.cfg.overvoltage_limit, 4'hF};
                        end
                        if (nxt == `NO_CHAN) d.st = S_IDLE;
                        else begin
                            d.chan = nxt;
                            d.st = S_REQ;
                        end
                    end
                end
            end
            S_CLEAR: begin
                if (q.cnt >= 32'(CLR_CYC - 1)) begin
                    d.res = {16{`RES_CLEARED}};
                    d.st = S_IDLE;
                end
            end
            S_DIAG: if (q.cnt >= 32'(DIAG_CYC - 1)) d.st = S_IDLE;
            default: d.st = S_IDLE;
        endcase

        // a new command restarts whatever is running
        if (cmdOk && measure) begin
            case (cmdCode)
                `CMD_CELL:    begin startCmd = 1'b1; startMode = MD_CELL;    end
                `CMD_CELL_DC: begin startCmd = 1'b1; startMode = MD_CELL_DC; end
                `CMD_OW:      begin startCmd = 1'b1; startMode = MD_OW;      end
                `CMD_OW_DC:   begin startCmd = 1'b1; startMode = MD_OW_DC;   end
                `CMD_TEST_A:  begin startCmd = 1'b1; startMode = MD_TEST_A;  end
                `CMD_TEST_B:  begin startCmd = 1'b1; startMode = MD_TEST_B;  end
                `CMD_CLEAR: begin
                    d.st = S_CLEAR;
                    d.cnt = 32'h0;
                end
                `CMD_DIAG: begin
                    d.mode = MD_DIAG;
                    d.chan = `REF_CHAN;
                    d.st = S_REQ;
                    d.cnt = 32'h0;
                end
                default: ;
            endcase
        end
        if (startCmd) begin
            d.mode = startMode;
            d.chan = seekChan(5'h00, skipFor(startMode, chanMask));
            d.st = (d.chan == `NO_CHAN) ? S_IDLE : S_REQ;
            d.cnt = 32'h0;
        end

        // standby aborts; partial results are left as they are
        if (!measure) begin
            d.st = S_IDLE;
            d.monCnt = 32'h0;
        end

        // discharge interlock
        d.dis = q.cfg.dischargeCfg;
        if (q.st == S_REQ || q.st == S_WAIT) begin
            if (q.mode == MD_CELL || q.mode == MD_OW) d.dis = q.cfg.dischargeCfg & ~neighbours(q.chan);
            else if (q.mode == MD_MON) d.dis = 12'h000;
        end

        // expiry wins over a same-cycle configuration write
        if (wdExpire) d.cfg = CFG_DEFAULT;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q <= '0;
            q.cfg <= CFG_DEFAULT;
            q.res <= {16{`RES_CLEARED}};
        end else begin
            q <= d;
        end
    end

    assign regRdata    = q.rdata;
    assign convBusy    = q.st != S_IDLE && q.mode != MD_MON;
    assign limitAlarm  = |(q.uvFlag | q.ovFlag);
    assign adcReq      = q.st == S_REQ;
    assign adcChan     = q.chan[3:0];
    assign adcOpenWire = q.mode == MD_OW || q.mode == MD_OW_DC;
    assign dischargeOn = q.dis;
    assign gpioOut     = 2'b00;
    assign gpioOeN     = {q.cfg.general_pin_two, q.cfg.general_pin_one};
    assign wdAlarmOut  = 1'b0;
    assign wdAlarmOeN  = !wdAlarm;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence cellHeld;
        (q.st == S_WAIT && q.mode == MD_CELL) [*2];
    endsequence
    sequence dcHeld;
        (q.st == S_WAIT && q.mode == MD_CELL_DC) [*2];
    endsequence
    sequence monHeld;
        (q.st == S_WAIT && q.mode == MD_MON) [*2];
    endsequence

    over_flag_a: assert property (q.st == S_WAIT && adcDone && isCellMode(q.mode) && !cmdOk && measure
        && code > {q.cfg.overvoltage_limit, 4'hF} |=> q.ovFlag[$past(q.chan[3:0])])
        else $error("overvoltage flag not set");
    start_busy_a: assert property (cmdOk && measure && cmdCode == `CMD_CELL && chanMask != 12'hFFF
        |=> convBusy && adcReq)
        else $error("start command did not begin conversion");
    bad_pec_a: assert property (cmdValid && !cmdPecOk && q.st == S_IDLE && q.monCnt != 32'h0
        && !regWr |=> q.st == S_IDLE && $stable(q.res))
        else $error("rejected command changed state");
    mask_skip_a: assert property (adcReq && q.mode != MD_DIAG && adcChan < 4'hC |-> !chanMask[adcChan])
        else $error("masked channel measured");
    ten_cell_a: assert property (adcReq && q.cfg.ten_cell_select && isCellMode(q.mode) |-> adcChan < 4'hA)
        else $error("cell eleven or twelve measured in ten-cell mode");
    code_offset_a: assert property (q.st == S_WAIT && adcDone && q.mode == MD_CELL && !cmdOk && measure
        |=> q.res[$past(adcChan)] == $past(adcRaw) + `ADC_OFFSET)
        else $error("result code not offset");
    force_off_a: assert property (cellHeld |-> (dischargeOn & neighbours(q.chan)) == 12'h000)
        else $error("discharge left on beside measured cell");
    keep_dc_a: assert property (dcHeld |-> dischargeOn == $past(q.cfg.dischargeCfg))
        else $error("discharge changed during discharge-on conversion");
    mon_off_a: assert property (monHeld |-> dischargeOn == 12'h000)
        else $error("discharge on during limit comparison");
    clear_time_a: assert property (q.st == S_CLEAR |-> q.cnt < 32'(CLR_CYC))
        else $error("clear overran its time");
    clear_fill_a: assert property (q.st == S_CLEAR && q.cnt == 32'(CLR_CYC - 1) && !cmdOk && measure
        |=> q.res == {16{`RES_CLEARED}})
        else $error("clear did not fill results");
    test_pat_a: assert property (q.st == S_WAIT && adcDone && q.mode == MD_TEST_A && !cmdOk && measure
        |=> q.res[$past(adcChan)] == `TEST_PAT_A)
        else $error("self test pattern missing");
    diag_time_a: assert property (q.st == S_DIAG |-> q.cnt < 32'(DIAG_CYC))
        else $error("diagnostic overran its time");
    standby_a: assert property (!measure |=> q.st == S_IDLE)
        else $error("activity in standby");
endmodule : cell_monitor_core

// ===== bench/adc_model.sv
// Purpose: converter stand-in answering each request once
// Assumes: one request outstanding at a time
// Notes: reading toggles outside the answer cycle
`timescale 1ns/10ps
module adc_model #(
    parameter int LAT = 3
) (
    // clock
    input  wire logic        clk,
    // converter handshake
    input  wire logic        adcReq,
    output logic             adcDone,
    output logic      [11:0] adcRaw,
    output logic             adcMuxOk
);
    int cnt = 0;
    assign adcMuxOk = 1'b1;
    initial begin
        adcDone = 1'b0;
        adcRaw  = 12'h5A5;
    end
    // stale reading never looks valid
    always @(posedge clk) begin
        adcDone <= 1'b0;
        adcRaw  <= ~adcRaw;
        if (adcReq)
            cnt <= LAT;
        else if (cnt == 1) begin
            adcDone <= 1'b1;
            adcRaw  <= 12'h123;
        end
        if (cnt > 0 && !adcReq)
            cnt <= cnt - 1;
    end
endmodule : adc_model

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the cell monitor core
// Assumes: short counts set by parameters
// Notes: open-drain lines pulled up in the bench
`timescale 1ns/10ps
module tb_top;
    import cell_monitor_pkg::*;
    logic clk = 0, rstn = 0, regWr = 0, regRd = 0, cmdValid = 0, cmdPecOk = 0;
    logic [3:0] regAddr = 0, cmdCode = 0;
    logic [7:0] regWdata = 0, regRdata, v, lo;
    logic convBusy, limitAlarm, adcReq, adcOpenWire, adcDone, adcMuxOk, wdAlarmOut, wdAlarmOeN;
    logic [3:0] adcChan;
    logic [11:0] adcRaw, dischargeOn;
    logic [1:0] gpioOut, gpioOeN;
    int err_count = 0, num_checks = 0, reqCnt = 0, busyCyc = 0;
    logic watchDis = 0, dcMode = 0, monWatch = 0;
    cell_monitor_core #(.CLR_CYC(20), .DIAG_CYC(60), .MON_CYC(100), .WD_CYC(200)) uut (.clk(clk), .rstn(rstn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdPecOk(cmdPecOk), .convBusy(convBusy),
        .limitAlarm(limitAlarm), .adcReq(adcReq), .adcChan(adcChan), .adcOpenWire(adcOpenWire),
        .adcDone(adcDone), .adcRaw(adcRaw), .adcMuxOk(adcMuxOk), .dischargeOn(dischargeOn),
        .gpioIn(gpioOeN), .gpioOut(gpioOut), .gpioOeN(gpioOeN), .wdAlarmIn(wdAlarmOeN),
        .wdAlarmOut(wdAlarmOut), .wdAlarmOeN(wdAlarmOeN));
    adc_model #(.LAT(3)) partner (.clk(clk), .adcReq(adcReq), .adcDone(adcDone), .adcRaw(adcRaw),
        .adcMuxOk(adcMuxOk));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk(input logic [11:0] g, input logic [11:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task complete_run;
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    task cmd(input logic [3:0] c, input logic ok);
        @(posedge clk);
        cmdValid <= 1'b1; cmdCode <= c; cmdPecOk <= ok;
        @(posedge clk);
        cmdValid <= 1'b0;
        #1;
    endtask : cmd
    task run(input logic [3:0] c);
        int i;
        reqCnt = 0;
        cmd(c, 1'b1);
        chk(convBusy, 1'b1);
        // look after the edge so the launched value has settled
        for (i = 0; i < 3000 && convBusy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        busyCyc = i;
        chk(convBusy, 1'b0);
    endtask : run
    task res(input logic [3:0] ch, input logic [11:0] e);
        wr(4'h7, {4'h0, ch});
        rd(4'h8, lo);
        rd(4'h9, v);
        chk({v[3:0], lo}, e);
    endtask : res
    always @(posedge clk) begin
        if (adcReq === 1'b1) reqCnt++;
        if (watchDis && convBusy === 1'b1 && adcReq === 1'b0 && adcChan === 4'h4)
            chk(dischargeOn[5:3], dcMode ? 3'h7 : 3'h0);
        if (monWatch && adcReq === 1'b0 && adcChan === 4'h4)
            chk(dischargeOn, 12'h000);
    end
    initial begin
        #2000000;
        err_count++;
        complete_run;
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(4'h0, v); chk(v, 8'hE0);
        rd(4'h5, v); chk(v, 8'hFF);
        wr(4'h0, 8'h01); wr(4'h1, 8'hFF); wr(4'h4, 8'h40);
        cmd(4'h1, 1'b0); chk(convBusy, 1'b0);
        watchDis = 1;
        run(4'h1); chk(reqCnt, 12);
        res(4'h0, 12'h323);
        rd(4'hA, v); chk(v, 8'hFF);
        chk(limitAlarm, 1'b1);
        dcMode = 1;
        run(4'h3);
        watchDis = 0;
        wr(4'h0, 8'h09);
        run(4'h1); chk(reqCnt, 10);
        run(4'h5); chk(12'(busyCyc), 12'h014); res(4'h3, 12'hFFF);
        run(4'h6); res(4'h1, 12'h555);
        run(4'h7); res(4'h2, 12'hAAA);
        run(4'h2); chk(adcOpenWire, 1'b1);
        run(4'h8); chk(12'(busyCyc), 12'h03C);
        res(4'hF, 12'h323);
        rd(4'h6, v); chk(v, 8'h02);
        wr(4'h5, 8'h10); reqCnt = 0; monWatch = 1;
        wr(4'h0, 8'h0A); repeat (60) @(posedge clk);
        #1 chk(reqCnt, 10); chk(convBusy, 1'b0);
        monWatch = 0; rd(4'hC, v); chk(v, 8'hFF);
        wr(4'h0, 8'h41); #1 chk(gpioOeN, 2'b10);
        chk({gpioOut, wdAlarmOut}, 3'h0);
        // pin readback goes through two synchroniser stages
        repeat (2) @(posedge clk);
        rd(4'h0, v); chk(v, 8'hC1);
        repeat (260) @(posedge clk);
        chk(wdAlarmOeN, 1'b0);
        rd(4'h0, v); chk(v, 8'h60);
        cmd(4'h1, 1'b0); chk(wdAlarmOeN, 1'b0);
        wr(4'h0, 8'h01); #1 chk(wdAlarmOeN, 1'b1);
        complete_run;
    end
endmodule : tb_top
